// ---- design/header_match.sv ----
// Masked header match engine with cumulative and/or result
`timescale 1ns/1ps
module header_match (
   // Clock and reset
   input  wire logic clk_sys_in,
   input  wire logic rst_in,
   // Carrier
   match_if.engine   m
);
   logic [3:0] here;
   logic [3:0] ok;
   logic [3:0] last;
   logic [3:0] en_v;
   logic       seen;
   logic       cum;
   logic       next_cum;
   logic       cur_ok;
   logic       cur_and;
   logic       any_here;

   // Per slot position, mask compare and last enabled slot
   for (genvar k = 0; k < 4; k++) begin : g_slot
      assign en_v[k] = m.cfg[k].en;
      assign here[k] = m.byte_valid && m.cfg[k].en && (m.byte_idx == {3'h0, m.cfg[k].ofs});
      assign ok[k]   = (m.byte_data & m.cfg[k].mask) == m.cfg[k].value;
      assign last[k] = en_v[k] && ((en_v >> (k + 1)) == 4'h0);
   end

   // Fold current slot into the running result
   assign any_here = |here;
   assign cur_ok   = |(here & ok);
   assign cur_and  = |(here & {m.cfg[3].and_sel, m.cfg[2].and_sel, m.cfg[1].and_sel, m.cfg[0].and_sel});
   assign next_cum = !seen ? cur_ok : (cur_and ? (cum & cur_ok) : (cum | cur_ok));

   // Running result, decision pulse at last enabled slot
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || m.start) begin
         seen      <= 1'b0;
         cum       <= 1'b0;
         m.decided <= 1'b0;
         m.pass    <= 1'b1;
      end else begin
         m.decided <= any_here && |(here & last);
         if (any_here) begin
            seen <= 1'b1;
            cum  <= next_cum;
            if (|(here & last)) begin
               m.pass <= next_cum;
            end
         end
      end
   end

   match_and_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (any_here && seen && cur_and && !m.start) |=> (cum == ($past(cum) & $past(cur_ok))))
      else $error("and combine of match slot wrong");
   match_pass_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      m.decided |-> (m.pass == cum))
      else $error("match decision differs from running result");
endmodule : header_match

// ---- design/match_if.sv ----
// Carrier between packet handler and header match engine
`timescale 1ns/1ps
interface match_if;
   rx_filter_hop_pkg::match_slot_s [3:0] cfg;
   logic       start;
   logic       byte_valid;
   logic [7:0] byte_idx;
   logic [7:0] byte_data;
   logic       decided;
   logic       pass;
   modport ctrl (output cfg, start, byte_valid, byte_idx, byte_data, input decided, pass);
   modport engine (input cfg, start, byte_valid, byte_idx, byte_data, output decided, pass);
endinterface : match_if

// ---- design/rx_filter_hop.sv ----
// Receive packet handler: length parsing, header match filter, automatic channel hopping
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "rx_filter_hop_params.svh"
// Summary of operation
// - Length field one or two bytes
// - Two-byte length either byte order
// - Length field stored or dropped
// - Up to four match bytes
// - Failed match can abort packet
// - Received byte masked then compared
// - Slot results chained by or/and
// - Frequency is base plus channel times step
// - Hop table of 64 channels
// - Base channel, table in order, wrap
// - All-ones entries are skipped
// - Outputs toggle on hop and wrap
// - Signal strength timeout in bit periods
// - Preamble timeout hops when absent
// - Preamble found keeps channel
// - Sync within length plus four bits
module rx_filter_hop #(
   parameter int DEPTH = `RFH_TABLE_DEPTH
) (
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Demodulator status
   input  wire logic        rx_settled_in,
   input  wire logic        bit_tick_in,
   input  wire logic [7:0]  rssi_in,
   input  wire logic        preamble_det_in,
   input  wire logic        nonpre_bit_in,
   input  wire logic        sync_found_in,
   input  wire logic        rx_byte_valid_in,
   input  wire logic [7:0]  rx_byte_in,
   // Receive queue and synthesizer
   output logic             fifo_wr_out,
   output logic [7:0]       fifo_data_out,
   output logic [31:0]      freq_out,
   output logic [7:0]       chan_out,
   // Events and general purpose outputs
   output logic             pkt_done_out,
   output logic             pkt_abort_out,
   output logic             gpio_hop_out,
   output logic             gpio_wrap_out
);
   match_if m ();
   header_match u_match (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .m(m));

   rx_filter_hop_pkg::hop_state_e state;
   rx_filter_hop_pkg::match_slot_s [3:0] slot;
   logic [`RFH_CTRL_W-1:0] ctrl;
   logic [7:0]  len_pos;
   logic [31:0] base;
   logic [15:0] step;
   logic [15:0] rssi_to;
   logic [15:0] pre_to;
   logic [7:0]  sync_len;
   logic [6:0]  hop_num;
   logic [7:0]  thresh;
   logic [7:0]  table_mem [DEPTH];
   logic [6:0]  pos;
   logic [15:0] bit_cnt;
   logic        rssi_ok;
   logic        sync_armed;
   logic [7:0]  rssi_prev;
   logic [7:0]  idx;
   logic [15:0] len;
   logic [15:0] data_cnt;
   logic        len_done;
   logic        last_pass;

   // APB decode
   logic        acc;
   logic        wr;
   logic        in_table;
   logic [5:0]  tab_idx;
   logic [3:0]  reg_idx;
   logic        mapped;
   logic [31:0] rd_mux;
   rx_filter_hop_pkg::match_slot_s wslot;
   logic [31:0] slot_rd [4];
   assign acc      = psel_in && penable_in && !pready_out;
   assign wr       = psel_in && penable_in && pready_out && pwrite_in && !pslverr_out;
   assign in_table = (paddr_in[11:8] == 4'h1) && ({1'b0, paddr_in[7:2]} < 7'(DEPTH)) && (paddr_in[1:0] == 2'h0);
   assign tab_idx  = paddr_in[7:2];
   assign reg_idx  = paddr_in[5:2];
   assign mapped   = in_table || ((paddr_in[11:6] == 6'h00) && (paddr_in[1:0] == 2'h0) && (reg_idx <= 4'hD));
   // Match slot fields taken from their bus positions
   assign wslot    = {pwdata_in[`RFH_M_EN], pwdata_in[`RFH_M_AND], pwdata_in[`RFH_M_OFS_LSB +: 5],
                      pwdata_in[`RFH_M_MSK_LSB +: 8], pwdata_in[`RFH_M_VAL_LSB +: 8]};
   // Match slot words rebuilt at their bus positions
   for (genvar k = 0; k < 4; k++) begin : g_slot_rd
      assign slot_rd[k] = {6'h0, slot[k].en, slot[k].and_sel, 3'h0, slot[k].ofs, slot[k].mask, slot[k].value};
   end
   always_comb begin
      case (paddr_in)
         `RFH_CTRL_OFS:       rd_mux = {22'h0, ctrl};
         `RFH_LENPOS_OFS:     rd_mux = {24'h0, len_pos};
         `RFH_MATCH0_OFS:         rd_mux = slot_rd[0];
         `RFH_MATCH0_OFS + 12'h4: rd_mux = slot_rd[1];
         `RFH_MATCH0_OFS + 12'h8: rd_mux = slot_rd[2];
         `RFH_MATCH0_OFS + 12'hC: rd_mux = slot_rd[3];
         `RFH_BASE_OFS:       rd_mux = base;
         `RFH_STEP_OFS:       rd_mux = {16'h0, step};
         `RFH_RSSITO_OFS:     rd_mux = {16'h0, rssi_to};
         `RFH_PRETO_OFS:      rd_mux = {16'h0, pre_to};
         `RFH_SYNCLEN_OFS:    rd_mux = {24'h0, sync_len};
         `RFH_HOPNUM_OFS:     rd_mux = {25'h0, hop_num};
         `RFH_THRESH_OFS:     rd_mux = {24'h0, thresh};
         `RFH_STATUS_OFS:     rd_mux = {12'h0, last_pass, state, 1'b0, pos, chan_out};
         default:             rd_mux = in_table ? {24'h0, table_mem[tab_idx]} : 32'h0;
      endcase
   end

   // APB answer one cycle into the access phase
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0;
      end else begin
         pready_out  <= acc;
         pslverr_out <= acc && !mapped;
         prdata_out  <= (acc && mapped && !pwrite_in) ? rd_mux : 32'h0;
      end
   end

   // Configuration registers
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ctrl     <= `RFH_CTRL_RST;
         len_pos  <= 8'h00;
         slot     <= '0;
         base     <= 32'h0;
         step     <= 16'h0;
         rssi_to  <= `RFH_TO_RST;
         pre_to   <= `RFH_TO_RST;
         sync_len <= `RFH_SYNCLEN_RST;
         hop_num  <= 7'h00;
         thresh   <= 8'h00;
      end else if (wr) begin
         case (paddr_in)
            `RFH_CTRL_OFS:       ctrl     <= pwdata_in[`RFH_CTRL_W-1:0];
            `RFH_LENPOS_OFS:     len_pos  <= pwdata_in[7:0];
            `RFH_MATCH0_OFS:         slot[0]  <= wslot;
            `RFH_MATCH0_OFS + 12'h4: slot[1]  <= wslot;
            `RFH_MATCH0_OFS + 12'h8: slot[2]  <= wslot;
            `RFH_MATCH0_OFS + 12'hC: slot[3]  <= wslot;
            `RFH_BASE_OFS:       base     <= pwdata_in;
            `RFH_STEP_OFS:       step     <= pwdata_in[15:0];
            `RFH_RSSITO_OFS:     rssi_to  <= pwdata_in[15:0];
            `RFH_PRETO_OFS:      pre_to   <= pwdata_in[15:0];
            `RFH_SYNCLEN_OFS:    sync_len <= pwdata_in[7:0];
            `RFH_HOPNUM_OFS:     hop_num  <= (pwdata_in[6:0] > 7'(DEPTH)) ? 7'(DEPTH) : pwdata_in[6:0];
            `RFH_THRESH_OFS:     thresh   <= pwdata_in[7:0];
            default:             ;
         endcase
      end
   end

   // Hop table, unused entries read as skip value
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         for (int i = 0; i < DEPTH; i++) table_mem[i] <= `RFH_SKIP_CHAN;
      end else if (wr && in_table) begin
         table_mem[tab_idx] <= pwdata_in[7:0];
      end
   end

   // Hop decisions
   logic [8:0]  rssi_sum;
   logic [7:0]  rssi_eff;
   logic        rssi_hit;
   logic        rssi_exp;
   logic        pre_exp;
   logic        sync_exp;
   logic        hop_req;
   logic        at_end;
   logic [7:0]  entry;
   logic [31:0] next_freq;
   assign rssi_sum  = {1'b0, rssi_in} + {1'b0, rssi_prev};
   assign rssi_eff  = ctrl[`RFH_C_AVG] ? rssi_sum[8:1] : rssi_in;
   assign rssi_hit  = bit_tick_in && (rssi_eff > thresh);
   assign rssi_exp  = ctrl[`RFH_C_RSSIEN] && !rssi_ok && (bit_cnt >= rssi_to);
   assign pre_exp   = ctrl[`RFH_C_PREEN] && (bit_cnt >= pre_to);
   assign sync_exp  = sync_armed && (bit_cnt >= ({8'h0, sync_len} + `RFH_SYNC_EXTRA));
   assign hop_req   = ((state == rx_filter_hop_pkg::ST_LISTEN) && (rssi_exp || pre_exp))
                   || ((state == rx_filter_hop_pkg::ST_SYNC) && sync_exp && !sync_found_in);
   assign at_end    = pos >= hop_num;
   assign entry     = table_mem[pos[5:0]];
   assign next_freq = base + ({24'h0, chan_out} * {16'h0, step});

   // Channel scan state machine
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state      <= rx_filter_hop_pkg::ST_SETTLE;
         pos        <= 7'h00;
         chan_out   <= 8'h00;
         bit_cnt    <= 16'h0;
         rssi_ok    <= 1'b0;
         sync_armed <= 1'b0;
         rssi_prev  <= 8'h00;
         gpio_hop_out  <= 1'b0;
         gpio_wrap_out <= 1'b0;
      end else begin
         if (bit_tick_in) rssi_prev <= rssi_in;
         if (bit_tick_in) bit_cnt <= bit_cnt + 16'h1;
         case (state)
            rx_filter_hop_pkg::ST_SETTLE: begin
               bit_cnt    <= 16'h0;
               rssi_ok    <= 1'b0;
               sync_armed <= 1'b0;
               if (rx_settled_in) state <= rx_filter_hop_pkg::ST_LISTEN;
            end
            rx_filter_hop_pkg::ST_LISTEN: begin
               if (rssi_hit) rssi_ok <= 1'b1;
               if (preamble_det_in) begin
                  state   <= rx_filter_hop_pkg::ST_SYNC;
                  bit_cnt <= 16'h0;
               end else if (hop_req) begin
                  state <= ctrl[`RFH_C_HOPEN] ? rx_filter_hop_pkg::ST_STEP : rx_filter_hop_pkg::ST_SETTLE;
               end
            end
            rx_filter_hop_pkg::ST_SYNC: begin
               if (!sync_armed) bit_cnt <= 16'h0;
               if (nonpre_bit_in && !sync_armed) sync_armed <= 1'b1;
               if (sync_found_in) begin
                  state <= rx_filter_hop_pkg::ST_PKT;
               end else if (hop_req) begin
                  state <= ctrl[`RFH_C_HOPEN] ? rx_filter_hop_pkg::ST_STEP : rx_filter_hop_pkg::ST_SETTLE;
               end
            end
            rx_filter_hop_pkg::ST_PKT: begin
               if (pkt_done_out || pkt_abort_out) state <= rx_filter_hop_pkg::ST_SETTLE;
            end
            rx_filter_hop_pkg::ST_STEP: begin
               if (at_end) begin
                  pos      <= 7'h00;
                  chan_out <= 8'h00;
                  state    <= rx_filter_hop_pkg::ST_SETTLE;
                  if (ctrl[`RFH_C_GWRAP]) gpio_wrap_out <= !gpio_wrap_out;
                  if (ctrl[`RFH_C_GHOP]) gpio_hop_out <= !gpio_hop_out;
               end else begin
                  pos <= pos + 7'h1;
                  if (entry != `RFH_SKIP_CHAN) begin
                     chan_out <= entry;
                     state    <= rx_filter_hop_pkg::ST_SETTLE;
                     if (ctrl[`RFH_C_GHOP]) gpio_hop_out <= !gpio_hop_out;
                  end
               end
            end
            default: state <= rx_filter_hop_pkg::ST_SETTLE;
         endcase
      end
   end

   // Synthesizer word follows the channel
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) freq_out <= 32'h0;
      else freq_out <= next_freq;
   end

   // Packet byte classification
   logic       pkt_byte;
   logic       len_b0;
   logic       len_b1;
   logic       in_len;
   logic       len_last;
   logic [15:0] len_new;
   logic       fail;
   assign pkt_byte = (state == rx_filter_hop_pkg::ST_PKT) && rx_byte_valid_in;
   assign len_b0   = idx == len_pos;
   assign len_b1   = ctrl[`RFH_C_LEN2] && (idx == len_pos + 8'h1);
   assign in_len   = len_b0 || len_b1;
   assign len_last = ctrl[`RFH_C_LEN2] ? len_b1 : len_b0;
   assign len_new  = len_b0 ? ((ctrl[`RFH_C_LEN2] && ctrl[`RFH_C_MSBF]) ? {rx_byte_in, 8'h00} : {8'h00, rx_byte_in})
                   : (ctrl[`RFH_C_MSBF] ? {len[15:8], rx_byte_in} : {rx_byte_in, len[7:0]});
   assign fail     = m.decided && !m.pass && ctrl[`RFH_C_ABORT];

   // Match engine connection
   assign m.cfg        = slot;
   assign m.start      = (state == rx_filter_hop_pkg::ST_SYNC) && sync_found_in;
   assign m.byte_valid = pkt_byte;
   assign m.byte_idx   = idx;
   assign m.byte_data  = rx_byte_in;

   // Length tracking, queue writes and packet end
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || m.start) begin
         idx           <= 8'h00;
         len           <= 16'h0;
         data_cnt      <= 16'h0;
         len_done      <= 1'b0;
         fifo_wr_out   <= 1'b0;
         fifo_data_out <= 8'h00;
         pkt_done_out  <= 1'b0;
         pkt_abort_out <= 1'b0;
      end else begin
         fifo_wr_out   <= pkt_byte && !(in_len && !ctrl[`RFH_C_LSTORE]) && !pkt_done_out && !pkt_abort_out;
         fifo_data_out <= rx_byte_in;
         pkt_abort_out <= fail && !pkt_abort_out && (state == rx_filter_hop_pkg::ST_PKT);
         pkt_done_out  <= 1'b0;
         if (pkt_byte) begin
            if (idx != 8'hFF) idx <= idx + 8'h1;
            if (in_len) len <= len_new;
            if (len_last) begin
               len_done <= 1'b1;
               pkt_done_out <= (len_new == 16'h0) && !fail;
            end
            if (len_done) begin
               data_cnt <= data_cnt + 16'h1;
               pkt_done_out <= (data_cnt + 16'h1 == len) && !fail;
            end
         end
      end
   end

   // Last match outcome for status
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) last_pass <= 1'b1;
      else if (m.decided) last_pass <= m.pass;
   end

   apb_ready_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (psel_in && penable_in && !pready_out) |=> pready_out)
      else $error("apb answer not given one cycle into access");
   skip_ff_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (state == rx_filter_hop_pkg::ST_STEP) ##1 (state == rx_filter_hop_pkg::ST_SETTLE) |-> chan_out != 8'hFF)
      else $error("hop landed on skipped channel");
   wrap_base_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (state == rx_filter_hop_pkg::ST_STEP && at_end && ctrl[`RFH_C_GWRAP]) |=>
      (chan_out == 8'h00 && pos == 7'h00 && gpio_wrap_out != $past(gpio_wrap_out)))
      else $error("table wrap did not return to base channel");
   freq_calc_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $stable(chan_out) && $stable(base) && $stable(step) |=>
      freq_out == $past(base) + ({24'h0, $past(chan_out)} * {16'h0, $past(step)}))
      else $error("frequency word wrong");
   pkt_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (state == rx_filter_hop_pkg::ST_PKT) |=> $stable(chan_out) && $stable(pos))
      else $error("channel changed during packet");
   sync_timeout_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (state == rx_filter_hop_pkg::ST_SYNC && sync_exp && !sync_found_in && ctrl[`RFH_C_HOPEN]) |=>
      state == rx_filter_hop_pkg::ST_STEP)
      else $error("missing sync did not hop");
   pre_timeout_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (state == rx_filter_hop_pkg::ST_LISTEN && pre_exp && !preamble_det_in && ctrl[`RFH_C_HOPEN]) |=>
      state == rx_filter_hop_pkg::ST_STEP)
      else $error("missing preamble did not hop");
   len_drop_a: assert property (@(posedge clk_sys_in) disable iff (rst_in || m.start)
      (pkt_byte && in_len && !ctrl[`RFH_C_LSTORE]) |=> !fifo_wr_out)
      else $error("length byte written while stripping");
   abort_fail_a: assert property (@(posedge clk_sys_in) disable iff (rst_in || m.start)
      (fail && state == rx_filter_hop_pkg::ST_PKT && !pkt_abort_out) |=> pkt_abort_out ##1 !fifo_wr_out)
      else $error("match failure did not abort");
   cov_pkt_c: cover property (@(posedge clk_sys_in) disable iff (rst_in) pkt_done_out);
   cov_abort_c: cover property (@(posedge clk_sys_in) disable iff (rst_in) pkt_abort_out);
   cov_wrap_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      state == rx_filter_hop_pkg::ST_STEP && at_end);
endmodule : rx_filter_hop

// ---- design/rx_filter_hop_params.svh ----
// Register map, field positions, reset values and fixed counts of the receive filter
`ifndef RX_FILTER_HOP_PARAMS_SVH
`define RX_FILTER_HOP_PARAMS_SVH
// Register byte offsets
`define RFH_CTRL_OFS      12'h000
`define RFH_LENPOS_OFS    12'h004
`define RFH_MATCH0_OFS    12'h008
`define RFH_BASE_OFS      12'h018
`define RFH_STEP_OFS      12'h01C
`define RFH_RSSITO_OFS    12'h020
`define RFH_PRETO_OFS     12'h024
`define RFH_SYNCLEN_OFS   12'h028
`define RFH_HOPNUM_OFS    12'h02C
`define RFH_THRESH_OFS    12'h030
`define RFH_STATUS_OFS    12'h034
`define RFH_TABLE_OFS     12'h100
// Control register bit positions
`define RFH_C_LEN2        0
`define RFH_C_MSBF        1
`define RFH_C_LSTORE      2
`define RFH_C_ABORT       3
`define RFH_C_HOPEN       4
`define RFH_C_RSSIEN      5
`define RFH_C_PREEN       6
`define RFH_C_GHOP        7
`define RFH_C_GWRAP       8
`define RFH_C_AVG         9
`define RFH_CTRL_W        10
// Match slot word layout
`define RFH_M_VAL_LSB     0
`define RFH_M_MSK_LSB     8
`define RFH_M_OFS_LSB     16
`define RFH_M_AND         24
`define RFH_M_EN          25
// Reset values and fixed values
`define RFH_CTRL_RST      10'h000
`define RFH_TO_RST        16'h0020
`define RFH_SYNCLEN_RST   8'h10
`define RFH_SKIP_CHAN     8'hFF
`define RFH_SYNC_EXTRA    16'h0004
`define RFH_TABLE_DEPTH   64
`endif

// ---- design/rx_filter_hop_pkg.sv ----
// Types shared by the receive filter modules
package rx_filter_hop_pkg;
   typedef struct packed {
      logic       en;
      logic       and_sel;
      logic [4:0] ofs;
      logic [7:0] mask;
      logic [7:0] value;
   } match_slot_s;
   typedef enum logic [2:0] {
      ST_SETTLE = 3'b000,
      ST_LISTEN = 3'b001,
      ST_SYNC   = 3'b010,
      ST_PKT    = 3'b011,
      ST_STEP   = 3'b100
   } hop_state_e;
endpackage : rx_filter_hop_pkg

// ---- verification/air_tx.sv ----
// Remote transmitter model driving the demodulator status lines
`timescale 1ns/1ps
module air_tx (
   // Clock
   input  wire logic       clk_in,
   // Demodulator side
   output logic            tick_out,
   output logic            pre_out,
   output logic            nonpre_out,
   output logic            sync_out,
   output logic            bv_out,
   output logic [7:0]      byte_out
);
   logic [1:0] div = 2'h0;
   logic [7:0] pkt [$];
   // Bit period of four clocks
   always @(posedge clk_in) begin
      div <= div + 2'h1;
   end
   assign tick_out = (div == 2'h3);
   // Lines idle at time zero
   initial begin
      {pre_out, nonpre_out, sync_out, bv_out} = 4'h0;
      byte_out = 8'h00;
   end
   // Burst of the whole packet, built in pkt beforehand
   task automatic send(input logic s);
      @(posedge clk_in) pre_out <= 1'b1;
      @(posedge clk_in) {pre_out, nonpre_out} <= 2'b01;
      @(posedge clk_in) {nonpre_out, sync_out} <= {1'b0, s};
      @(posedge clk_in) sync_out <= 1'b0;
      foreach (pkt[i]) begin
         @(posedge clk_in) {bv_out, byte_out} <= {1'b1, pkt[i]};
         @(posedge clk_in) {bv_out, byte_out} <= {1'b0, ~pkt[i]};
      end
   endtask : send
endmodule : air_tx

// ---- verification/tb.sv ----
// Testbench for the receive packet filter and channel hopping
`timescale 1ns/1ps
`include "rx_filter_hop_params.svh"
module tb;
   logic        clk_sys_in = 1'b0;
   logic        rst_in     = 1'b1;
   logic        psel       = 1'b0;
   logic        pen        = 1'b0;
   logic        pwr        = 1'b0;
   logic [11:0] paddr      = 12'h000;
   logic [31:0] pwdata     = 32'h0;
   logic [31:0] prdata, freq;
   logic        pready, pslverr, err, tick, pre, nonpre, sync, bv;
   logic        fwr, done, abrt, ghop, gwrap;
   logic [7:0]  rb, fdata, chan;
   logic [7:0]  rssi       = 8'h00;
   logic [7:0]  got [$];
   logic [7:0]  p1 [$] = '{8'hAA, 8'h03, 8'h11, 8'h22, 8'h33};
   int          fails = 0, total_checks = 0, n_done = 0, n_abort = 0;
   // Clock
   always #4 clk_sys_in = ~clk_sys_in;
   air_tx tx (.clk_in(clk_sys_in), .tick_out(tick), .pre_out(pre), .nonpre_out(nonpre),
              .sync_out(sync), .bv_out(bv), .byte_out(rb));
   rx_filter_hop dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .rx_settled_in(1'b1), .bit_tick_in(tick), .rssi_in(rssi),
      .preamble_det_in(pre), .nonpre_bit_in(nonpre), .sync_found_in(sync), .rx_byte_valid_in(bv),
      .rx_byte_in(rb), .fifo_wr_out(fwr), .fifo_data_out(fdata), .freq_out(freq), .chan_out(chan),
      .pkt_done_out(done), .pkt_abort_out(abrt), .gpio_hop_out(ghop), .gpio_wrap_out(gwrap));
   // Record queue writes and packet events
   always @(posedge clk_sys_in) begin
      if (fwr === 1'b1) got.push_back(fdata);
      if (done === 1'b1) n_done++;
      if (abrt === 1'b1) n_abort++;
   end
   task automatic chk(input logic [31:0] g, e, input string m);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      k = 0;
      @(posedge clk_sys_in) {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk_sys_in) pen <= 1'b1;
      do @(posedge clk_sys_in); while (pready !== 1'b1 && ++k < 20);
      chk(pready, 1'b1, "ready");
      r = prdata;
      err = pslverr;
      {psel, pen} <= 2'b00;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask : wr
   task automatic run_pkt(input logic [7:0] p [$], e [$], input int ed, ea);
      int d0, a0;
      got.delete();
      d0 = n_done;
      a0 = n_abort;
      tx.pkt = p;
      tx.send(1'b1);
      repeat (4) @(posedge clk_sys_in);
      if (ea == 0) chk(got.size(), e.size(), "count");
      if (ea == 0) foreach (e[i]) chk(got[i], e[i], "byte");
      chk(n_done - d0, ed, "done");
      chk(n_abort - a0, ea, "abort");
   endtask : run_pkt
   task automatic t_reg;
      logic [31:0] r;
      apb(1'b0, `RFH_SYNCLEN_OFS, 32'h0, r);
      chk(r, 32'h10, "sync len");
      wr(`RFH_TABLE_OFS + 12'h0FC, 32'h12);
      apb(1'b0, `RFH_TABLE_OFS + 12'h0FC, 32'h0, r);
      chk(r, 32'h12, "entry 63");
      apb(1'b0, 12'h0F0, 32'h0, r);
      chk(err, 1'b1, "unmapped");
   endtask : t_reg
   task automatic t_len;
      wr(`RFH_LENPOS_OFS, 32'h1);
      wr(`RFH_CTRL_OFS, 32'h004);
      run_pkt(p1, p1, 1, 0);
      wr(`RFH_CTRL_OFS, 32'h003);
      run_pkt('{8'hAA, 8'h00, 8'h02, 8'h44, 8'h55}, '{8'hAA, 8'h44, 8'h55}, 1, 0);
      wr(`RFH_CTRL_OFS, 32'h001);
      run_pkt('{8'hAA, 8'h02, 8'h00, 8'h66, 8'h77}, '{8'hAA, 8'h66, 8'h77}, 1, 0);
   endtask : t_len
   task automatic t_match;
      logic [31:0] r;
      wr(`RFH_CTRL_OFS, 32'h00C);
      wr(`RFH_MATCH0_OFS, 32'h0200_F0A0);
      apb(1'b0, `RFH_MATCH0_OFS, 32'h0, r);
      chk(r, 32'h0200_F0A0, "slot read");
      run_pkt(p1, p1, 1, 0);
      wr(`RFH_MATCH0_OFS, 32'h0200_F0B0);
      run_pkt(p1, p1, 0, 1);
      wr(`RFH_MATCH0_OFS + 12'h4, 32'h0202_FF11);
      run_pkt(p1, p1, 1, 0);
      wr(`RFH_MATCH0_OFS + 12'h4, 32'h0302_FF11);
      run_pkt(p1, p1, 0, 1);
   endtask : t_match
   task automatic t_hop;
      logic [7:0] e [4] = '{8'h05, 8'h09, 8'h00, 8'h05};
      logic [7:0] c0;
      int k;
      wr(`RFH_TABLE_OFS, 32'h05);
      wr(`RFH_TABLE_OFS + 12'h4, 32'hFF);
      wr(`RFH_TABLE_OFS + 12'h8, 32'h09);
      wr(`RFH_HOPNUM_OFS, 32'h3);
      wr(`RFH_BASE_OFS, 32'h1000);
      wr(`RFH_STEP_OFS, 32'h10);
      wr(`RFH_PRETO_OFS, 32'h4);
      wr(`RFH_RSSITO_OFS, 32'h4);
      wr(`RFH_THRESH_OFS, 32'h20);
      wr(`RFH_CTRL_OFS, 32'h190);
      tx.pkt.delete();
      tx.send(1'b0);
      for (int i = 0; i < 4; i++) begin
         c0 = chan;
         k = 0;
         while (chan === c0 && k < 2000) begin
            @(posedge clk_sys_in);
            k++;
         end
         repeat (2) @(posedge clk_sys_in);
         if (i == 0) chk(k > 70 && k < 90, 1'b1, "sync wait");
         chk(chan, e[i], "chan");
         chk(freq, 32'h1000 + e[i] * 32'h10, "freq");
         chk({ghop, gwrap}, {i[0] == 1'b0, i >= 2}, "gpio");
         if (i == 0) wr(`RFH_CTRL_OFS, 32'h1D0);
      end
      // Signal strength condition alone, with averaging
      wr(`RFH_CTRL_OFS, 32'h3B0);
      c0 = chan;
      k = 0;
      while (chan === c0 && k < 2000) begin
         @(posedge clk_sys_in);
         k++;
      end
      rssi <= 8'h80;
      chk(chan, 8'h09, "rssi hop");
      repeat (80) @(posedge clk_sys_in);
      chk(chan, 8'h09, "rssi stay");
   endtask : t_hop
   task automatic test_done;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      t_reg;
      t_len;
      t_match;
      t_hop;
      test_done;
   end
   // Watchdog
   initial begin
      #400000;
      fails++;
      test_done;
   end
endmodule : tb
